// ---- verilog/xbus_decode_params.svh ----
/*
  Constants for the peripheral bus decoder: address windows, enable bit
  positions, wait-state counts and region bounds.
  Assumes a 24-bit linear CPU byte address and a 16-bit enable register.
*/
// Function
// - First CAN window EF00-EFFF selected when global enable and enable bit 0 set.
// - Second CAN window EE00-EEFF selected when global enable and enable bit 1 set.
// - Real time clock window ED00-EDFF needs global enable and enable bit 4.
// - Pulse-width unit window EC00-ECFF needs global enable and enable bit 6.
// - Async serial window E900-E9FF needs global enable and enable bit 7.
// - Sync serial window E800-E8FF needs global enable and enable bit 8.
// - I2C window EA00-EAFF needs global enable and enable bit 9.
// - Miscellaneous window EB00-EBFF needs global enable and enable bit 10.
// - Config register bit 2 gates all windows; clear means no window selected.
// - Window accesses are demultiplexed, 16-bit, word only; byte accesses refused.
// - Window accesses get exactly two wait states, no tristate wait state.
// - With either CAN in use, Port 4 outputs only four segment lines.
// - Disabled peripheral claims no window, pins or interrupts.
// - After end-of-init, clocks of disabled peripherals stop; RAMs and misc stay.
// - Clock gating never raises any reset.
// - Peripheral enable register is readable, and writable until end-of-init.
// - 1024 bytes reserved for function registers, two 512-byte word areas.
// - Flash fetches use 32-bit path, flash register reads 16-bit path.
// - Flash writes accepted only in flash control register area.
// - Extension RAM not usable as stack, register bank, nor bit addressable.
// - First extension RAM E000-E7FF needs global enable and enable bit 2.
// - Second extension RAM range needs global enable and enable bit 3.
`ifndef XBUS_DECODE_PARAMS_SVH
`define XBUS_DECODE_PARAMS_SVH
`define ADDR_W 24
`define FIRST_CAN_CONTROLLER_BASE 24'h00EF00
`define SECOND_CAN_CONTROLLER_BASE 24'h00EE00
`define RTC_BASE 24'h00ED00
`define PWM_BASE 24'h00EC00
`define ASC_BASE 24'h00E900
`define SSC_BASE 24'h00E800
`define I2C_BASE 24'h00EA00
`define MISC_BASE 24'h00EB00
`define PAGE_MASK 24'hFFFF00
`define XRAM1_LO 24'h00E000
`define XRAM1_HI 24'h00E7FF
`define SFR_LO 24'h00FE00
`define EXTENDED_SPECIAL_FUNCTION_REG_LO 24'h00F000
`define SFR_AREA_BYTES 24'h000200
`define FLASH_LO 24'h000000
`define FLASH_HI 24'h04FFFF
`define FLASH_LOW_HI 24'h007FFF
`define FLASH_UPPER_LO 24'h018000
`define FLASH_REG_LO 24'h080000
`define FLASH_REG_HI 24'h080015
`define XRAM2_MASK_RESET 24'hFFC000
`define XRAM2_BASE_RESET 24'h090000
`define BIT_FIRST_CAN_CONTROLLER 0
`define BIT_SECOND_CAN_CONTROLLER 1
`define BIT_XRAM1 2
`define BIT_XRAM2 3
`define BIT_RTC 4
`define BIT_PWM 6
`define BIT_ASC 7
`define BIT_SSC 8
`define BIT_I2C 9
`define BIT_MISC 10
`define CFG_GLOBAL_BIT 2
`define PERIPH_EN_RESET 16'h0401
`define PERIPH_EN_WMASK 16'h07DF
`define WAIT_STATES 2'h2
`define SEG_LINES_CAN 4'h4
`define SEG_LINES_ALL 4'h8
`endif

// ---- verilog/xbus_decode_pkg.sv ----
/*
  Types shared by the decoder and its wait-state counter.
  Assumes the params header is included alongside.
*/
package xbus_decode_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_DONE = 2'b10
  } acc_state_t;
  typedef enum logic [3:0] {
    TGT_NONE = 4'h0,
    TGT_FIRST_CAN_CONTROLLER = 4'h1,
    TGT_SECOND_CAN_CONTROLLER = 4'h2,
    TGT_RTC = 4'h3,
    TGT_PWM = 4'h4,
    TGT_ASC = 4'h5,
    TGT_SSC = 4'h6,
    TGT_I2C = 4'h7,
    TGT_MISC = 4'h8,
    TGT_XRAM1 = 4'h9,
    TGT_XRAM2 = 4'hA,
    TGT_FLASH = 4'hB,
    TGT_EXT = 4'hC
  } target_t;
endpackage

// ---- verilog/xbus_wait_if.sv ----
/*
  Start/done handshake between the decoder and its wait-state counter.
  Assumes a single clock domain.
*/
`timescale 1ns/1ps
interface xbus_wait_if;
  logic start;
  logic done;
  modport master (output start, input done);
  modport counter (input start, output done);
endinterface

// ---- verilog/xbus_wait_counter.sv ----
/*
  Wait-state counter: after a start pulse, counts the fixed wait states
  and then pulses done for one cycle.
  Assumes start is not raised again before done.
*/
`timescale 1ns/1ps
`include "xbus_decode_params.svh"
module xbus_wait_counter (
  input wire logic i_clk,
  input wire logic i_resetn,
  xbus_wait_if.counter w
);
  import xbus_decode_pkg::*;
  logic [1:0] count;
  logic busy;
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      count <= 2'h0;
      busy <= 1'b0;
      w.done <= 1'b0;
    end else begin
      w.done <= 1'b0;
      if (w.start) begin
        busy <= 1'b1;
        count <= 2'h1;
      end else if (busy) begin
        if (count == `WAIT_STATES) begin
          busy <= 1'b0;
          w.done <= 1'b1;
        end else begin
          count <= count + 2'h1;
        end
      end
    end
  end
endmodule // xbus_wait_counter

// ---- verilog/xbus_periph_decode.sv ----
/*
  Peripheral bus address decoder, enable register and clock gating.
  Assumes the CPU holds address and strobes steady from request until ready,
  and that the system configuration input comes from the same clock.
*/
`timescale 1ns/1ps
`include "xbus_decode_params.svh"
module xbus_periph_decode (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic i_req,
  input wire logic i_write,
  input wire logic i_byte,
  input wire logic i_fetch,
  input wire logic i_bit_access,
  input wire logic i_stack_access,
  input wire logic [23:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic [15:0] i_system_config_reg,
  input wire logic i_periph_en_we,
  input wire logic i_end_of_init_instruction,
  input wire logic [23:0] i_xram2_base,
  input wire logic [23:0] i_xram2_mask,
  output logic o_ready,
  output logic o_error,
  output logic [3:0] o_target,
  output logic [10:0] o_periph_sel,
  output logic o_xram1_sel,
  output logic o_xram2_sel,
  output logic o_ext_sel,
  output logic o_flash_sel,
  output logic o_flash_wide,
  output logic o_sfr_sel,
  output logic o_extended_special_function_reg_sel,
  output logic [15:0] o_periph_enable_reg,
  output logic [10:0] o_periph_clk_en,
  output logic o_periph_bus_global_enable,
  output logic [3:0] o_port4_seg_lines,
  output logic o_end_of_init_done,
  output logic o_reset_req
);
  import xbus_decode_pkg::*;

  function automatic logic in_page(input logic [23:0] a, input logic [23:0] base);
    in_page = ((a & `PAGE_MASK) == base);
  endfunction

  // The array has a hole between its low and upper sectors; the peripheral pages sit in it.
  function automatic logic in_flash_array(input logic [23:0] a);
    in_flash_array = (a <= `FLASH_LOW_HI) || ((a >= `FLASH_UPPER_LO) && (a <= `FLASH_HI));
  endfunction

  logic [15:0] periph_enable_reg;
  logic end_of_init_done;
  acc_state_t state;
  target_t next_target;
  target_t target;
  logic next_error;
  logic global_en;
  xbus_wait_if wif ();

  assign global_en = i_system_config_reg[`CFG_GLOBAL_BIT];

  // Decode priority: peripheral pages first, then RAM, flash, flash register area, external.
  always_comb begin
    next_target = TGT_EXT;
    next_error = 1'b0;
    if (global_en) begin
      if (in_page(i_addr, `FIRST_CAN_CONTROLLER_BASE) && periph_enable_reg[`BIT_FIRST_CAN_CONTROLLER]) next_target = TGT_FIRST_CAN_CONTROLLER;
      else if (in_page(i_addr, `SECOND_CAN_CONTROLLER_BASE) && periph_enable_reg[`BIT_SECOND_CAN_CONTROLLER]) next_target = TGT_SECOND_CAN_CONTROLLER;
      else if (in_page(i_addr, `RTC_BASE) && periph_enable_reg[`BIT_RTC]) next_target = TGT_RTC;
      else if (in_page(i_addr, `PWM_BASE) && periph_enable_reg[`BIT_PWM]) next_target = TGT_PWM;
      else if (in_page(i_addr, `ASC_BASE) && periph_enable_reg[`BIT_ASC]) next_target = TGT_ASC;
      else if (in_page(i_addr, `SSC_BASE) && periph_enable_reg[`BIT_SSC]) next_target = TGT_SSC;
      else if (in_page(i_addr, `I2C_BASE) && periph_enable_reg[`BIT_I2C]) next_target = TGT_I2C;
      else if (in_page(i_addr, `MISC_BASE) && periph_enable_reg[`BIT_MISC]) next_target = TGT_MISC;
      else if (i_addr >= `XRAM1_LO && i_addr <= `XRAM1_HI && periph_enable_reg[`BIT_XRAM1])
        next_target = TGT_XRAM1;
      else if (((i_addr & i_xram2_mask) == (i_xram2_base & i_xram2_mask)) && periph_enable_reg[`BIT_XRAM2])
        next_target = TGT_XRAM2;
    end
    if (next_target == TGT_EXT) begin
      if (in_flash_array(i_addr)) next_target = TGT_FLASH;
      else if (i_addr >= `FLASH_REG_LO && i_addr <= `FLASH_REG_HI) next_target = TGT_FLASH;
    end
    if (next_target inside {TGT_FIRST_CAN_CONTROLLER, TGT_SECOND_CAN_CONTROLLER, TGT_RTC, TGT_PWM, TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC})
      next_error = i_byte;
    if (next_target == TGT_FLASH && i_write && in_flash_array(i_addr))
      next_error = 1'b1;
    if ((next_target == TGT_XRAM1 || next_target == TGT_XRAM2) && (i_bit_access || i_stack_access))
      next_error = 1'b1;
  end

  // Software writes land only on implemented bits so read-back matches.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      periph_enable_reg <= `PERIPH_EN_RESET;
    end else if (i_periph_en_we && !end_of_init_done) begin
      periph_enable_reg <= i_wdata & `PERIPH_EN_WMASK;
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      end_of_init_done <= 1'b0;
    end else if (i_end_of_init_instruction) begin
      end_of_init_done <= 1'b1;
    end
  end

  // Gating is a pure clock enable; it never reaches the reset network.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      o_periph_clk_en <= 11'h7FF;
      o_reset_req <= 1'b0;
    end else begin
      o_reset_req <= 1'b0;
      for (int k = 0; k < 11; k++) begin
        if (k == `BIT_XRAM1 || k == `BIT_XRAM2 || k == `BIT_MISC) o_periph_clk_en[k] <= 1'b1;
        else o_periph_clk_en[k] <= !end_of_init_done || (global_en && periph_enable_reg[k]);
      end
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      o_periph_enable_reg <= 16'h0000;
      o_periph_bus_global_enable <= 1'b0;
      o_port4_seg_lines <= `SEG_LINES_ALL;
      o_end_of_init_done <= 1'b0;
    end else begin
      o_periph_enable_reg <= periph_enable_reg;
      o_periph_bus_global_enable <= global_en;
      o_end_of_init_done <= end_of_init_done;
      if (global_en && (periph_enable_reg[`BIT_FIRST_CAN_CONTROLLER] || periph_enable_reg[`BIT_SECOND_CAN_CONTROLLER]))
        o_port4_seg_lines <= `SEG_LINES_CAN;
      else
        o_port4_seg_lines <= `SEG_LINES_ALL;
    end
  end

  // Access sequencer: accepted peripheral page accesses wait on the counter, others answer next cycle.
  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      state <= ST_IDLE;
      target <= TGT_NONE;
      wif.start <= 1'b0;
      o_ready <= 1'b0;
      o_error <= 1'b0;
    end else begin
      wif.start <= 1'b0;
      o_ready <= 1'b0;
      o_error <= 1'b0;
      unique case (state)
        ST_IDLE: begin
          target <= TGT_NONE;
          if (i_req) begin
            target <= next_target;
            if (next_error) begin
              // A refused access selects nothing, so no peripheral sees a stray strobe.
              target <= TGT_NONE;
              o_ready <= 1'b1;
              o_error <= 1'b1;
              state <= ST_DONE;
            end else if (next_target inside {TGT_FIRST_CAN_CONTROLLER, TGT_SECOND_CAN_CONTROLLER, TGT_RTC, TGT_PWM,
                                             TGT_ASC, TGT_SSC, TGT_I2C, TGT_MISC}) begin
              wif.start <= 1'b1;
              state <= ST_WAIT;
            end else begin
              o_ready <= 1'b1;
              state <= ST_DONE;
            end
          end
        end
        ST_WAIT: begin
          if (wif.done) begin
            o_ready <= 1'b1;
            state <= ST_DONE;
          end
        end
        ST_DONE: begin
          target <= TGT_NONE;
          state <= ST_IDLE;
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESETN) begin
    if (!I_RESETN) begin
      o_target <= 4'h0;
      o_periph_sel <= 11'h000;
      o_xram1_sel <= 1'b0;
      o_xram2_sel <= 1'b0;
      o_ext_sel <= 1'b0;
      o_flash_sel <= 1'b0;
      o_flash_wide <= 1'b0;
      o_sfr_sel <= 1'b0;
      o_extended_special_function_reg_sel <= 1'b0;
    end else begin
      o_target <= 4'(target);
      o_periph_sel <= 11'h000;
      o_periph_sel[`BIT_FIRST_CAN_CONTROLLER] <= (target == TGT_FIRST_CAN_CONTROLLER);
      o_periph_sel[`BIT_SECOND_CAN_CONTROLLER] <= (target == TGT_SECOND_CAN_CONTROLLER);
      o_periph_sel[`BIT_RTC] <= (target == TGT_RTC);
      o_periph_sel[`BIT_PWM] <= (target == TGT_PWM);
      o_periph_sel[`BIT_ASC] <= (target == TGT_ASC);
      o_periph_sel[`BIT_SSC] <= (target == TGT_SSC);
      o_periph_sel[`BIT_I2C] <= (target == TGT_I2C);
      o_periph_sel[`BIT_MISC] <= (target == TGT_MISC);
      o_xram1_sel <= (target == TGT_XRAM1);
      o_xram2_sel <= (target == TGT_XRAM2);
      o_ext_sel <= (target == TGT_EXT);
      o_flash_sel <= (target == TGT_FLASH);
      o_flash_wide <= (target == TGT_FLASH) && i_fetch && in_flash_array(i_addr);
      o_sfr_sel <= (i_addr >= `SFR_LO) && (i_addr < `SFR_LO + `SFR_AREA_BYTES);
      o_extended_special_function_reg_sel <= (i_addr >= `EXTENDED_SPECIAL_FUNCTION_REG_LO) && (i_addr < `EXTENDED_SPECIAL_FUNCTION_REG_LO + `SFR_AREA_BYTES);
    end
  end

  xbus_wait_counter u_wait (
    .i_clk(I_CLK),
    .i_resetn(I_RESETN),
    .w(wif.counter)
  );
endmodule // xbus_periph_decode

// ---- tb/xbus_periph_decode_asserts.sv ----
/*
  Port checker for the peripheral decoder, bound to its top module below.
  Assumes one clock and the active-low asynchronous reset of the decoder.
*/
`timescale 1ns/1ps
module xbus_periph_decode_asserts (
  input wire logic I_CLK,
  input wire logic I_RESETN,
  input wire logic i_write,
  input wire logic [23:0] i_addr,
  input wire logic o_ready,
  input wire logic o_error,
  input wire logic [10:0] o_periph_sel,
  input wire logic o_ext_sel,
  input wire logic [15:0] o_periph_enable_reg,
  input wire logic [10:0] o_periph_clk_en,
  input wire logic o_periph_bus_global_enable,
  input wire logic o_reset_req
);
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RESETN);
  a_ready_pulse: assert property (o_ready |=> !o_ready) else $error("ready held too long");
  a_error_ready: assert property (o_error |-> o_ready) else $error("error without ready");
  a_sel_global: assert property (|o_periph_sel |-> o_periph_bus_global_enable) else $error("select while off");
  a_sel_onehot: assert property ($onehot0(o_periph_sel)) else $error("two windows selected");
  a_sel_enabled: assert property ((o_periph_sel & ~o_periph_enable_reg[10:0]) == 11'h000)
    else $error("disabled window selected");
  // Select rises one cycle after the counter start; ready follows the two wait states and the done cycle.
  a_wait_states: assert property ($rose(|o_periph_sel) |-> !o_ready [*3] ##1 o_ready)
    else $error("wrong wait state count");
  a_ext_excl: assert property (o_ext_sel |-> o_periph_sel == 11'h000) else $error("external and window");
  a_flash_write: assert property (o_ready && i_write && i_addr < 24'h008000 |-> o_error)
    else $error("flash array write accepted");
  a_ram_clocked: assert property (o_periph_clk_en[10] && o_periph_clk_en[3:2] == 2'b11)
    else $error("ram or misc clock stopped");
  a_no_reset: assert property (!o_reset_req) else $error("reset raised");
  c_window: cover property ($rose(|o_periph_sel));
  c_refused: cover property (o_error);
  c_external: cover property (o_ready && o_ext_sel);
endmodule // xbus_periph_decode_asserts

bind xbus_periph_decode xbus_periph_decode_asserts port_chk (.I_CLK, .I_RESETN, .i_write, .i_addr, .o_ready,
  .o_error, .o_periph_sel, .o_ext_sel, .o_periph_enable_reg, .o_periph_clk_en, .o_periph_bus_global_enable,
  .o_reset_req);

// ---- tb/xbus_periph_model.sv ----
/*
  Peripheral-side model: counts window selects per peripheral.
  Assumes the decoder clock and select lines are wired straight in.
*/
`timescale 1ns/1ps
module xbus_periph_model (
  input wire logic i_clk,
  input wire logic [10:0] i_sel,
  input wire logic [10:0] i_clk_en
);
  int cnt [11];
  int bad = 0;
  logic [10:0] prev = 11'h000;
  // A stopped peripheral cannot answer, so a select reaching one is a lost access.
  always @(posedge i_clk) begin
    prev <= i_sel;
    for (int i = 0; i < 11; i++) begin
      if (i_sel[i] && !prev[i]) cnt[i] = cnt[i] + 1;
      if (i_sel[i] && !i_clk_en[i]) bad = bad + 1;
    end
  end
endmodule // xbus_periph_model

// ---- tb/xbus_peripheral_decode_gating_tb.sv ----
/*
  Self-checking bench for the peripheral decoder with a peripheral model.
  Assumes the design files and package are compiled first.
*/
`timescale 1ns/1ps
module xbus_peripheral_decode_gating_tb;
  import xbus_decode_pkg::*;
  logic I_CLK = 1'b0;
  logic I_RESETN = 1'b0;
  logic i_req = 1'b0, i_write = 1'b0, i_byte = 1'b0, i_fetch = 1'b0, i_bit_access = 1'b0;
  logic i_stack_access = 1'b0, i_periph_en_we = 1'b0, i_end_of_init_instruction = 1'b0;
  logic [23:0] i_addr = 24'h000000;
  logic [23:0] i_xram2_base = 24'h090000;
  logic [23:0] i_xram2_mask = 24'hFFC000;
  logic [15:0] i_wdata = 16'h0000;
  logic [15:0] i_system_config_reg = 16'h0000;
  logic o_ready, o_error, o_xram1_sel, o_xram2_sel, o_ext_sel, o_flash_sel, o_flash_wide, o_sfr_sel, o_extended_special_function_reg_sel;
  logic o_periph_bus_global_enable, o_end_of_init_done, o_reset_req;
  logic [3:0] o_target, o_port4_seg_lines;
  logic [10:0] o_periph_sel, o_periph_clk_en;
  logic [15:0] o_periph_enable_reg, c_tgt, c_sel, c_err, c_wide, c_sfr, c_oth;
  int fail_count = 0, cmp_count = 0, cyc = 0, lat = 0, lat_ext = 0;
  logic [23:0] wbase [8] = '{24'h00EF00, 24'h00EE00, 24'h00ED00, 24'h00EC00,
    24'h00E900, 24'h00E800, 24'h00EA00, 24'h00EB00};
  int wbit [8] = '{0, 1, 4, 6, 7, 8, 9, 10};

  xbus_periph_decode DUT (.I_CLK, .I_RESETN, .i_req, .i_write, .i_byte, .i_fetch, .i_bit_access, .i_stack_access,
    .i_addr, .i_wdata, .i_system_config_reg, .i_periph_en_we, .i_end_of_init_instruction, .i_xram2_base,
    .i_xram2_mask, .o_ready, .o_error, .o_target, .o_periph_sel, .o_xram1_sel, .o_xram2_sel, .o_ext_sel,
    .o_flash_sel, .o_flash_wide, .o_sfr_sel, .o_extended_special_function_reg_sel, .o_periph_enable_reg, .o_periph_clk_en,
    .o_periph_bus_global_enable, .o_port4_seg_lines, .o_end_of_init_done, .o_reset_req);
  xbus_periph_model model (.i_clk(I_CLK), .i_sel(o_periph_sel), .i_clk_en(o_periph_clk_en));

  always #20 I_CLK = ~I_CLK;

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  always @(posedge I_CLK) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t timeout", $time);
      close_out;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    cmp_count = cmp_count + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Request is held until ready is seen; the error flag stands with ready, selects one cycle later.
  task automatic acc(input logic [23:0] a, input logic w, input logic b);
    @(negedge I_CLK);
    i_addr = a;
    i_write = w;
    i_byte = b;
    i_req = 1'b1;
    lat = 0;
    do begin
      @(negedge I_CLK);
      lat = lat + 1;
    end while (o_ready !== 1'b1 && lat < 20);
    c_err = 16'(o_error);
    i_req = 1'b0;
    @(negedge I_CLK);
    c_tgt = 16'(o_target);
    c_sel = 16'(o_periph_sel);
    c_wide = 16'(o_flash_wide);
    c_sfr = 16'(o_sfr_sel);
    c_oth = 16'({o_extended_special_function_reg_sel, o_flash_sel, o_ext_sel, o_xram2_sel, o_xram1_sel});
    @(negedge I_CLK);
  endtask

  task automatic wen(input logic [15:0] v);
    @(negedge I_CLK);
    i_wdata = v;
    i_periph_en_we = 1'b1;
    @(negedge I_CLK);
    i_periph_en_we = 1'b0;
    repeat (2) @(negedge I_CLK);
  endtask

  initial begin
    repeat (10) @(negedge I_CLK);
    I_RESETN = 1'b1;
    @(negedge I_CLK);
    chk(o_periph_enable_reg, 16'h0401, "enable reset");
    chk(16'(o_periph_clk_en), 16'h07FF, "clocks before init");
    acc(24'h00EF00, 1'b0, 1'b0);
    lat_ext = lat;
    chk(c_tgt, 16'(TGT_EXT), "global off target");
    chk(c_sel, 16'h0000, "global off select");
    chk(c_oth, 16'h0004, "global off external select");
    i_system_config_reg = 16'h0004;
    wen(16'h07DF);
    chk(o_periph_enable_reg, 16'h07DF, "enable readback");
    chk(16'(o_periph_bus_global_enable), 16'h0001, "global enable shown");
    chk(16'(o_port4_seg_lines), 16'h0004, "segment lines with CAN");
    for (int i = 0; i < 8; i++) begin
      acc(wbase[i] | 24'(i * 36), 1'b1, 1'b0);
      chk(c_tgt, 16'(i + 1), "window target");
      chk(c_sel, 16'h0001 << wbit[i], "window select");
      chk(16'(lat), 16'(lat_ext + 4), "window latency");
      chk(16'(model.cnt[wbit[i]]), 16'h0001, "peripheral reached");
    end
    acc(24'h00EC10, 1'b0, 1'b1);
    chk(c_err, 16'h0001, "byte refused");
    wen(16'h0000);
    acc(24'h00EF00, 1'b0, 1'b0);
    chk(c_tgt, 16'(TGT_EXT), "disabled window");
    chk(16'(o_port4_seg_lines), 16'h0008, "segment lines without CAN");
    acc(24'h00E000, 1'b0, 1'b0);
    chk(c_tgt, 16'(TGT_EXT), "ram one off");
    wen(16'h000C);
    acc(24'h00E7FE, 1'b0, 1'b0);
    chk(c_tgt, 16'(TGT_XRAM1), "ram one on");
    chk(c_oth, 16'h0001, "ram one select");
    acc(24'h090010, 1'b1, 1'b0);
    chk(c_tgt, 16'(TGT_XRAM2), "ram two on");
    chk(c_oth, 16'h0002, "ram two select");
    i_bit_access = 1'b1;
    acc(24'h00E010, 1'b0, 1'b0);
    i_bit_access = 1'b0;
    chk(c_err, 16'h0001, "bit access to ram");
    i_stack_access = 1'b1;
    acc(24'h090020, 1'b1, 1'b0);
    i_stack_access = 1'b0;
    chk(c_err, 16'h0001, "stack access to ram");
    i_fetch = 1'b1;
    acc(24'h000100, 1'b0, 1'b0);
    i_fetch = 1'b0;
    chk(c_wide, 16'h0001, "wide fetch");
    acc(24'h000100, 1'b1, 1'b0);
    chk(c_err, 16'h0001, "flash array write");
    acc(24'h080000, 1'b1, 1'b0);
    chk(c_err, 16'h0000, "flash register write");
    chk(c_oth, 16'h0008, "flash register select");
    acc(24'h00FE10, 1'b0, 1'b0);
    chk(c_sfr, 16'h0001, "function register area");
    acc(24'h00F010, 1'b0, 1'b0);
    chk(c_oth, 16'h0014, "extended register area");
    wen(16'h0011);
    i_end_of_init_instruction = 1'b1;
    @(negedge I_CLK);
    i_end_of_init_instruction = 1'b0;
    repeat (3) @(negedge I_CLK);
    chk(16'(o_periph_clk_en & 11'h7DF), 16'h041D, "gated clocks");
    chk(16'(o_reset_req), 16'h0000, "no reset after gating");
    chk(16'(o_end_of_init_done), 16'h0001, "end of init shown");
    acc(24'h00EF00, 1'b0, 1'b0);
    chk(c_tgt, 16'(TGT_FIRST_CAN_CONTROLLER), "enabled after init");
    chk(16'(model.bad), 16'h0000, "select to stopped unit");
    close_out;
  end
endmodule // xbus_peripheral_decode_gating_tb
